//--- logic/lock_detect.sv
`timescale 1ns/1ps
`default_nettype none

`include "pll_ctrl_defs.svh"

module lock_detect (
   input  wire logic   core_clk,
   input  wire logic   rst_n,
   pll_ctrl_if.lock    lk
);
   import pll_ctrl_pkg::*;

   lock_s      q;
   lock_s      d;
   logic [7:0] target;
   logic [7:0] win;
   logic [7:0] unlock;

   always_comb begin
      case (lk.cnt_sel)
         2'b00:   target = `LD_CYC_5;
         2'b01:   target = `LD_CYC_16;
         2'b10:   target = `LD_CYC_64;
         default: target = `LD_CYC_255;
      endcase
      win    = lk.win_low ? `LOCK_WIN_LOW : `LOCK_WIN_HIGH;
      unlock = lk.win_low ? `UNLOCK_LOW   : `UNLOCK_HIGH;
   end

   always_comb begin
      d = q;
      if (lk.ld_disable) begin
         d.flag = 1'b0;
         d.cnt  = 8'h00;
      end else if (lk.cmp_edge) begin
         if (!q.flag) begin
            if (lk.edge_diff < win) begin
               if (({1'b0, q.cnt} + 9'h001) >= {1'b0, target}) begin
                  d.flag = 1'b1;
                  d.cnt  = 8'h00;
               end else begin
                  d.cnt = q.cnt + 8'h01;
               end
            end else begin
               d.cnt = 8'h00;
            end
         end else if (lk.edge_diff > unlock) begin
            d.flag = 1'b0;
            d.cnt  = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lk.digital_lock_flag = q.flag;

   AST_LOCK_AFTER_COUNT: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(q.flag) |-> ($past(q.cnt) == $past(target) - 8'h01) && $past(lk.edge_diff) < $past(win))
      else $error("lock flag set before the cycle count was reached");

   AST_DISABLE_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
      lk.ld_disable |=> !q.flag && q.cnt == 8'h00)
      else $error("lock detect still active while disabled");

   AST_HYSTERESIS_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.flag && !lk.ld_disable && (!lk.cmp_edge || lk.edge_diff <= unlock)) |=> q.flag)
      else $error("lock flag dropped inside loss-of-lock threshold");

   AST_UNLOCK_ABOVE: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.flag && lk.cmp_edge && lk.edge_diff > (lk.win_low ? `UNLOCK_LOW : `UNLOCK_HIGH)) |=> !q.flag)
      else $error("lock flag kept beyond loss-of-lock threshold");

endmodule : lock_detect

`default_nettype wire

//--- logic/pll_ctrl_defs.svh
`ifndef PLL_CTRL_DEFS_SVH
`define PLL_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_ABL_CFG      10'h017
`define ADDR_LD_CAL_CFG   10'h018
`define ADDR_UPDATE       10'h232
`define ADDR_IRQ_STATUS   10'h0F0
`define ADDR_IRQ_MASK     10'h0F1
`define ADDR_LIVE_STATUS  10'h0F2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ABL_SEL_MSB       1
`define ABL_SEL_LSB       0
`define LD_CNT_MSB        6
`define LD_CNT_LSB        5
`define LD_WIN_BIT        4
`define LD_DIS_BIT        3
`define CAL_DIV_MSB       2
`define CAL_DIV_LSB       1
`define CAL_NOW_BIT       0
`define UPDATE_BIT        0
`define IRQ_LOCK_GAIN     0
`define IRQ_LOCK_LOSS     1
`define IRQ_CAL_DONE      2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ABL_CFG_RST       2'h0
`define LD_CAL_CFG_RST    8'h06
`define IRQ_MASK_RST      3'h0

// ----------------------------------------------------------------
// antibacklash widths in tenths of a nanosecond
// ----------------------------------------------------------------
`define ABL_W_2P9         6'h1D
`define ABL_W_1P3         6'h0D
`define ABL_W_6P0         6'h3C

// ----------------------------------------------------------------
// lock detect counts and windows (edge_diff units)
// ----------------------------------------------------------------
`define LD_CYC_5          8'h05
`define LD_CYC_16         8'h10
`define LD_CYC_64         8'h40
`define LD_CYC_255        8'hFF
`define LOCK_WIN_HIGH     8'h10
`define UNLOCK_HIGH       8'h20
`define LOCK_WIN_LOW      8'h06
`define UNLOCK_LOW        8'h0C

// ----------------------------------------------------------------
// calibration timing
// ----------------------------------------------------------------
`define CAL_DIV_TERM_2    4'h1
`define CAL_DIV_TERM_4    4'h3
`define CAL_DIV_TERM_8    4'h7
`define CAL_DIV_TERM_16   4'hF
`define CAL_LEN_TICKS     8'h20

`endif

//--- logic/pll_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pll_ctrl_if;
   logic       ld_disable;
   logic       win_low;
   logic [1:0] cnt_sel;
   logic       cmp_edge;
   logic [7:0] edge_diff;
   logic       digital_lock_flag;
   logic [1:0] cal_div_sel;
   logic       ref_tick;
   logic       cal_start;
   logic       cal_tick;
   logic       cal_busy;
   logic       cal_done;

   modport ctl  (output ld_disable, win_low, cnt_sel, cmp_edge, edge_diff, cal_div_sel, ref_tick, cal_start,
                 input  digital_lock_flag, cal_tick, cal_busy, cal_done);
   modport lock (input  ld_disable, win_low, cnt_sel, cmp_edge, edge_diff,
                 output digital_lock_flag);
   modport cal  (input  cal_div_sel, ref_tick, cal_start,
                 output cal_tick, cal_busy, cal_done);
endinterface : pll_ctrl_if

`default_nettype wire

//--- logic/pll_ctrl_pkg.sv
`default_nettype none

`include "pll_ctrl_defs.svh"

package pll_ctrl_pkg;

   typedef enum logic [0:0] {
      CAL_IDLE = 1'b0,
      CAL_RUN  = 1'b1
   } cal_state_e;

   typedef struct packed {
      logic       flag;
      logic [7:0] cnt;
   } lock_s;

   typedef struct packed {
      cal_state_e state;
      logic [3:0] div_cnt;
      logic       tick;
      logic [7:0] cal_cnt;
      logic       done;
   } cal_s;

   typedef struct packed {
      logic [1:0] abl_buf;
      logic [7:0] cfg_buf;
      logic [1:0] abl_act;
      logic [7:0] cfg_act;
      logic       cal_now_prev;
      logic       lock_prev;
      logic [2:0] irq_sts;
      logic [2:0] irq_msk;
      logic [7:0] rdata;
      logic [5:0] width;
   } top_s;

endpackage : pll_ctrl_pkg

`default_nettype wire

//--- logic/pll_ctrl_top.sv
// Behaviour
// - two-bit select sets antibacklash width: 00/11 2.9 ns, 01 1.3 ns, 10 6.0 ns
// - lock flag needs 5, 16, 64 or 255 consecutive in-window comparator cycles
// - lock flag sets when edge time difference is below the lock window
// - once set, flag holds until difference exceeds the loss-of-lock threshold of the selected window
// - disable bit 3 high turns lock detection off; low is normal
// - calibration clock is reference divided by 2, 4, 8 or 16, default 16
// - calibration starts only on a 0-to-1 change of the committed calibrate-now bit
`timescale 1ns/1ps
`default_nettype none

`include "pll_ctrl_defs.svh"

module pll_ctrl_top (
   input  wire logic       CORE_CLK,
   input  wire logic       RST_N,
   input  wire logic [9:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR_STB,
   input  wire logic       RD_STB,
   output logic      [7:0] RDATA,
   input  wire logic       CMP_EDGE,
   input  wire logic [7:0] EDGE_DIFF,
   input  wire logic       REF_TICK,
   output logic      [5:0] PULSE_WIDTH,
   output logic            LOCK_FLAG,
   output logic            CAL_CLK_TICK,
   output logic            CAL_BUSY,
   output logic            IRQ
);
   import pll_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   pll_ctrl_if pc ();

   lock_detect u_lock (
      .core_clk (CORE_CLK),
      .rst_n    (RST_N),
      .lk       (pc.lock)
   );

   vco_cal_seq u_cal (
      .core_clk (CORE_CLK),
      .rst_n    (RST_N),
      .cl       (pc.cal)
   );

   top_s       q;
   top_s       d;
   logic       wr_abl;
   logic       wr_cfg;
   logic       wr_upd;
   logic       wr_sts;
   logic       wr_msk;
   logic [2:0] irq_evt;
   logic       cal_start;

   // ----------------------------------------------------------------
   // decode and control wiring
   // ----------------------------------------------------------------
   assign wr_abl = WR_STB && (ADDR == `ADDR_ABL_CFG);
   assign wr_cfg = WR_STB && (ADDR == `ADDR_LD_CAL_CFG);
   assign wr_upd = WR_STB && (ADDR == `ADDR_UPDATE) && WDATA[`UPDATE_BIT];
   assign wr_sts = WR_STB && (ADDR == `ADDR_IRQ_STATUS);
   assign wr_msk = WR_STB && (ADDR == `ADDR_IRQ_MASK);

   // only an edge of the committed copy counts, so a bit parked at 1 is harmless
   assign cal_start = q.cfg_act[`CAL_NOW_BIT] && !q.cal_now_prev;

   assign pc.ld_disable  = q.cfg_act[`LD_DIS_BIT];
   assign pc.win_low     = q.cfg_act[`LD_WIN_BIT];
   assign pc.cnt_sel     = q.cfg_act[`LD_CNT_MSB:`LD_CNT_LSB];
   assign pc.cal_div_sel = q.cfg_act[`CAL_DIV_MSB:`CAL_DIV_LSB];
   assign pc.cmp_edge    = CMP_EDGE;
   assign pc.edge_diff   = EDGE_DIFF;
   assign pc.ref_tick    = REF_TICK;
   assign pc.cal_start   = cal_start;

   // ----------------------------------------------------------------
   // events
   // ----------------------------------------------------------------
   always_comb begin
      irq_evt                 = 3'h0;
      irq_evt[`IRQ_LOCK_GAIN] = pc.digital_lock_flag && !q.lock_prev;
      irq_evt[`IRQ_LOCK_LOSS] = !pc.digital_lock_flag && q.lock_prev;
      irq_evt[`IRQ_CAL_DONE]  = pc.cal_done;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d              = q;
      d.cal_now_prev = q.cfg_act[`CAL_NOW_BIT];
      d.lock_prev    = pc.digital_lock_flag;
      d.rdata        = 8'h00;

      if (wr_abl) begin
         d.abl_buf = WDATA[`ABL_SEL_MSB:`ABL_SEL_LSB];
      end
      if (wr_cfg) begin
         d.cfg_buf = WDATA;
      end
      // buffered copies reach the logic only through the update strobe
      if (wr_upd) begin
         d.abl_act = q.abl_buf;
         d.cfg_act = q.cfg_buf;
      end
      if (wr_msk) begin
         d.irq_msk = WDATA[2:0];
      end

      // a new event beats a clear written in the same cycle
      d.irq_sts = (q.irq_sts & ~(wr_sts ? WDATA[2:0] : 3'h0)) | irq_evt;

      case (q.abl_act)
         2'b01:   d.width = `ABL_W_1P3;
         2'b10:   d.width = `ABL_W_6P0;
         default: d.width = `ABL_W_2P9;
      endcase

      if (RD_STB) begin
         case (ADDR)
            `ADDR_ABL_CFG:     d.rdata = {6'h00, q.abl_buf};
            `ADDR_LD_CAL_CFG:  d.rdata = q.cfg_buf;
            `ADDR_IRQ_STATUS:  d.rdata = {5'h00, q.irq_sts};
            `ADDR_IRQ_MASK:    d.rdata = {5'h00, q.irq_msk};
            `ADDR_LIVE_STATUS: d.rdata = {6'h00, pc.cal_busy, pc.digital_lock_flag};
            default:           d.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         q              <= '0;
         q.abl_buf      <= `ABL_CFG_RST;
         q.abl_act      <= `ABL_CFG_RST;
         q.cfg_buf      <= `LD_CAL_CFG_RST;
         q.cfg_act      <= `LD_CAL_CFG_RST;
         q.irq_msk      <= `IRQ_MASK_RST;
         q.width        <= `ABL_W_2P9;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign RDATA        = q.rdata;
   assign PULSE_WIDTH  = q.width;
   assign LOCK_FLAG    = pc.digital_lock_flag;
   assign CAL_CLK_TICK = pc.cal_tick;
   assign CAL_BUSY     = pc.cal_busy;
   assign IRQ          = |(q.irq_sts & q.irq_msk);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_ABL_WIDTH_CODE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (q.abl_act == 2'b11) |=> PULSE_WIDTH == 6'h1D)
      else $error("code 11 did not give the 2.9 ns antibacklash width");

   AST_ABL_WIDTH_SHORT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (q.abl_act == 2'b01) |=> PULSE_WIDTH == 6'h0D)
      else $error("code 01 did not give the 1.3 ns antibacklash width");

   AST_HELD_BIT_NO_RESTART: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (q.cfg_act[`CAL_NOW_BIT] ##1 q.cfg_act[`CAL_NOW_BIT]) |-> !cal_start)
      else $error("calibration restarted from a held bit");

   AST_WRITE_NEEDS_UPDATE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (wr_cfg && !wr_upd) |=> q.cfg_act == $past(q.cfg_act))
      else $error("configuration reached the active copy without update");

   AST_UPDATE_COMMITS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      wr_upd |=> q.cfg_act == $past(q.cfg_buf) && q.abl_act == $past(q.abl_buf))
      else $error("update strobe did not commit the buffered registers");

   AST_CAL_SEQUENCE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (wr_upd && !q.cfg_act[`CAL_NOW_BIT] && q.cfg_buf[`CAL_NOW_BIT]) |=> cal_start)
      else $error("0-to-1 commit of calibrate-now gave no start");

   AST_EVENT_BEATS_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (wr_sts && |(irq_evt & WDATA[2:0])) |=> (q.irq_sts & $past(irq_evt)) == $past(irq_evt))
      else $error("interrupt event lost to a status clear in the same cycle");

   AST_READ_ONE_LATER: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (RD_STB && ADDR == `ADDR_LD_CAL_CFG) |=> RDATA == $past(q.cfg_buf) ##1 (RDATA == 8'h00 || $past(RD_STB)))
      else $error("read data not presented in the cycle after the strobe");

endmodule : pll_ctrl_top

`default_nettype wire

//--- logic/vco_cal_seq.sv
`timescale 1ns/1ps
`default_nettype none

`include "pll_ctrl_defs.svh"

module vco_cal_seq (
   input  wire logic   core_clk,
   input  wire logic   rst_n,
   pll_ctrl_if.cal     cl
);
   import pll_ctrl_pkg::*;

   cal_s       q;
   cal_s       d;
   logic [3:0] term;

   always_comb begin
      case (cl.cal_div_sel)
         2'b00:   term = `CAL_DIV_TERM_2;
         2'b01:   term = `CAL_DIV_TERM_4;
         2'b10:   term = `CAL_DIV_TERM_8;
         default: term = `CAL_DIV_TERM_16;
      endcase
   end

   always_comb begin
      d      = q;
      d.tick = 1'b0;
      d.done = 1'b0;
      if (cl.ref_tick) begin
         // a shrunk divide value while counting wraps rather than overrunning
         if (q.div_cnt >= term) begin
            d.div_cnt = 4'h0;
            d.tick    = 1'b1;
         end else begin
            d.div_cnt = q.div_cnt + 4'h1;
         end
      end
      case (q.state)
         CAL_IDLE: begin
            if (cl.cal_start) begin
               d.state   = CAL_RUN;
               d.cal_cnt = 8'h00;
            end
         end
         CAL_RUN: begin
            if (q.tick) begin
               if (q.cal_cnt == `CAL_LEN_TICKS - 8'h01) begin
                  d.state = CAL_IDLE;
                  d.done  = 1'b1;
               end else begin
                  d.cal_cnt = q.cal_cnt + 8'h01;
               end
            end
         end
         default: d.state = CAL_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cl.cal_tick = q.tick;
   assign cl.cal_busy = (q.state == CAL_RUN);
   assign cl.cal_done = q.done;

   AST_CAL_ONLY_ON_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(q.state == CAL_RUN) |-> $past(cl.cal_start))
      else $error("calibration began without a start request");

   AST_DIV_TICK_AT_TERM: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cl.ref_tick && q.div_cnt == term) |=> q.tick && q.div_cnt == 4'h0)
      else $error("calibration clock divider missed its terminal count");

endmodule : vco_cal_seq

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "pll_ctrl_defs.svh"

module tb;
   // ---------------------------------------------------------------
   // stimulus and observation signals
   // ---------------------------------------------------------------
   logic       core_clk = 1'b0;
   logic       rst_n;
   logic [9:0] addr;
   logic [7:0] wdata;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rdata;
   logic       cmp_edge;
   logic [7:0] edge_diff;
   logic       ref_tick = 1'b0;
   logic [5:0] pulse_width;
   logic       lock_flag;
   logic       cal_clk_tick;
   logic       cal_busy;
   logic       irq;
   int         miscompares;
   int         total_checks;
   int         cycles;
   int         ticks;
   int         busy;
   logic [5:0] abl_tbl [4] = '{`ABL_W_2P9, `ABL_W_1P3, `ABL_W_6P0, `ABL_W_2P9};
   int         cnt_tbl [4] = '{5, 16, 64, 255};
   logic [7:0] win_tbl [2] = '{`LOCK_WIN_HIGH, `LOCK_WIN_LOW};
   logic [7:0] unl_tbl [2] = '{`UNLOCK_HIGH, `UNLOCK_LOW};

   pll_ctrl_top i_pll_ctrl_top (
      .CORE_CLK     (core_clk),
      .RST_N        (rst_n),
      .ADDR         (addr),
      .WDATA        (wdata),
      .WR_STB       (wr_stb),
      .RD_STB       (rd_stb),
      .RDATA        (rdata),
      .CMP_EDGE     (cmp_edge),
      .EDGE_DIFF    (edge_diff),
      .REF_TICK     (ref_tick),
      .PULSE_WIDTH  (pulse_width),
      .LOCK_FLAG    (lock_flag),
      .CAL_CLK_TICK (cal_clk_tick),
      .CAL_BUSY     (cal_busy),
      .IRQ          (irq)
   );

   // ---------------------------------------------------------------
   // clocks and hang guard
   // ---------------------------------------------------------------
   always #50 core_clk = ~core_clk;

   // reference pulses every other cycle so the divider sees gaps
   always @(posedge core_clk) begin
      ref_tick <= ~ref_tick;
   end

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         miscompares++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // compare, bus and helper tasks
   // ---------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      chk_byte(rdata, exp);
   endtask : rd

   task automatic cfg(input logic [7:0] v);
      wr(`ADDR_LD_CAL_CFG, v);
      wr(`ADDR_UPDATE, 8'h01);
      settle(2);
   endtask : cfg

   // disable then re-enable so the lock state starts from zero
   task automatic fresh(input logic [7:0] v);
      cfg(v | 8'h08);
      cfg(v);
   endtask : fresh

   task automatic pulses(input int n, input logic [7:0] diff);
      @(posedge core_clk);
      cmp_edge  <= 1'b1;
      edge_diff <= diff;
      repeat (n) @(posedge core_clk);
      cmp_edge  <= 1'b0;
      settle(3);
   endtask : pulses

   task automatic conclude;
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n        = 1'b0;
      addr         = '0;
      wdata        = '0;
      wr_stb       = 1'b0;
      rd_stb       = 1'b0;
      cmp_edge     = 1'b0;
      edge_diff    = '0;
      miscompares  = 0;
      total_checks = 0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      settle(1);
      chk_byte({2'b00, pulse_width}, {2'b00, `ABL_W_2P9});
      chk_bit(lock_flag, 1'b0);
      chk_bit(irq, 1'b0);
      rd(`ADDR_ABL_CFG, 8'h00);
      rd(`ADDR_LD_CAL_CFG, 8'h06);
      rd(`ADDR_IRQ_STATUS, 8'h00);
      rd(`ADDR_IRQ_MASK, 8'h00);
      rd(10'h3FF, 8'h00);

      // an update strobe written as zero must not commit anything
      wr(`ADDR_ABL_CFG, 8'h01);
      wr(`ADDR_UPDATE, 8'h00);
      settle(2);
      chk_byte({2'b00, pulse_width}, {2'b00, `ABL_W_2P9});
      for (int c = 0; c < 4; c++) begin
         wr(`ADDR_ABL_CFG, 8'(c));
         wr(`ADDR_UPDATE, 8'h01);
         settle(2);
         chk_byte({2'b00, pulse_width}, {2'b00, abl_tbl[c]});
         rd(`ADDR_ABL_CFG, 8'(c));
      end
      wr(10'h3FF, 8'hFF);
      rd(`ADDR_ABL_CFG, 8'h03);

      for (int s = 0; s < 4; s++) begin
         fresh(8'(s << 5));
         rd(`ADDR_LD_CAL_CFG, 8'(s << 5));
         pulses(cnt_tbl[s] - 1, 8'h01);
         chk_bit(lock_flag, 1'b0);
         pulses(1, 8'h01);
         chk_bit(lock_flag, 1'b1);
      end

      // a difference equal to the window breaks the run of cycles
      for (int r = 0; r < 2; r++) begin
         fresh(8'(r << 4));
         pulses(4, win_tbl[r] - 8'h01);
         pulses(1, win_tbl[r]);
         pulses(4, win_tbl[r] - 8'h01);
         chk_bit(lock_flag, 1'b0);
         pulses(1, win_tbl[r] - 8'h01);
         chk_bit(lock_flag, 1'b1);
         pulses(1, unl_tbl[r]);
         chk_bit(lock_flag, 1'b1);
         pulses(1, unl_tbl[r] + 8'h01);
         chk_bit(lock_flag, 1'b0);
      end

      fresh(8'h00);
      pulses(5, 8'h01);
      rd(`ADDR_LIVE_STATUS, 8'h01);
      cfg(8'h08);
      chk_bit(lock_flag, 1'b0);
      pulses(10, 8'h01);
      chk_bit(lock_flag, 1'b0);

      cfg(8'h00);
      wr(`ADDR_IRQ_STATUS, 8'h07);
      rd(`ADDR_IRQ_STATUS, 8'h00);
      pulses(4, 8'h01);
      // fifth pulse locks; the clear of bit 0 lands on the edge where the event is taken
      @(posedge core_clk);
      cmp_edge <= 1'b1;
      @(posedge core_clk);
      cmp_edge <= 1'b0;
      addr     <= `ADDR_IRQ_STATUS;
      wdata    <= 8'h01;
      wr_stb   <= 1'b1;
      @(posedge core_clk);
      wr_stb   <= 1'b0;
      rd(`ADDR_IRQ_STATUS, 8'h01);
      chk_bit(irq, 1'b0);
      wr(`ADDR_IRQ_MASK, 8'h01);
      settle(2);
      chk_bit(irq, 1'b1);
      rd(`ADDR_IRQ_MASK, 8'h01);
      wr(`ADDR_IRQ_STATUS, 8'h01);
      settle(2);
      chk_bit(irq, 1'b0);
      pulses(1, `UNLOCK_HIGH + 8'h01);
      rd(`ADDR_IRQ_STATUS, 8'h02);

      for (int d = 0; d < 4; d++) begin
         cfg(8'(d << 1));
         settle(40);
         ticks = 0;
         repeat (128) begin
            @(posedge core_clk);
            #1;
            if (cal_clk_tick === 1'b1) ticks++;
         end
         chk_byte(8'(ticks), 8'(64 >> (d + 1)));
      end

      // divide by 2 on a half-rate reference keeps the run near 128 cycles
      wr(`ADDR_IRQ_STATUS, 8'h07);
      wr(`ADDR_IRQ_MASK, 8'h04);
      cfg(8'h00);
      cfg(8'h01);
      chk_bit(cal_busy, 1'b1);
      rd(`ADDR_LIVE_STATUS, 8'h02);
      busy = 0;
      while (cal_busy === 1'b1 && busy < 300) begin
         @(posedge core_clk);
         #1;
         busy++;
      end
      chk_bit(busy >= 116 && busy <= 134, 1'b1);
      settle(2);
      rd(`ADDR_IRQ_STATUS, 8'h04);
      chk_bit(irq, 1'b1);
      cfg(8'h01);
      settle(8);
      chk_bit(cal_busy, 1'b0);
      cfg(8'h00);
      cfg(8'h01);
      chk_bit(cal_busy, 1'b1);
      conclude();
   end
endmodule : tb

`default_nettype wire
